/* File: core/uims_pkg.sv */
// Purpose: Shared constants, types and helpers of the serial port interrupt mask/status block
// Assumes: AHB-Lite slave, 32-bit words, offsets decoded from the low 12 address bits
// Notes: Seven sources sit in bits 10:4 of every interrupt register
package uims_pkg;
    // Address window decoded inside the peripheral slot
    localparam int unsigned UIMS_AW = 12;
    // Register byte offsets
    localparam logic [11:0] UIMS_OFS_MASK = 12'h038;
    localparam logic [11:0] UIMS_OFS_RAW = 12'h03c;
    localparam logic [11:0] UIMS_OFS_MIS = 12'h040;
    localparam logic [11:0] UIMS_OFS_CLR = 12'h044;
    // Field placement of the seven sources inside a word
    localparam int unsigned UIMS_SRC_LSB = 4;
    localparam int unsigned UIMS_SRC_MSB = 10;
    localparam int unsigned UIMS_NSRC = 7;
    // Source index inside the field (word bit minus UIMS_SRC_LSB)
    localparam int unsigned UIMS_I_RX = 0;
    localparam int unsigned UIMS_I_TX = 1;
    localparam int unsigned UIMS_I_RT = 2;
    localparam int unsigned UIMS_I_FE = 3;
    localparam int unsigned UIMS_I_PE = 4;
    localparam int unsigned UIMS_I_BE = 5;
    localparam int unsigned UIMS_I_OE = 6;
    // Reset values
    localparam logic [6:0] UIMS_FIELD_RST = 7'h00;
    localparam logic [31:0] UIMS_WORD_ZERO = 32'h0000_0000;
    localparam logic UIMS_HRESP_OKAY = 1'h0;
    localparam logic UIMS_HREADY_RST = 1'h1;
    // Bit of htrans that marks NONSEQ or SEQ
    localparam int unsigned UIMS_HTRANS_ACT = 1;

    typedef logic [6:0] uims_field_t;
    // Decoded register selection
    typedef enum logic [2:0] {
        UIMS_REG_NONE,
        UIMS_REG_MASK,
        UIMS_REG_RAW,
        UIMS_REG_MIS,
        UIMS_REG_CLR
    } uims_reg_e;

    // Offset to register selection, used for both read and write phases
    function automatic uims_reg_e uims_decode(input logic [11:0] ofs);
        if (ofs == UIMS_OFS_MASK) begin
            return UIMS_REG_MASK;
        end else if (ofs == UIMS_OFS_RAW) begin
            return UIMS_REG_RAW;
        end else if (ofs == UIMS_OFS_MIS) begin
            return UIMS_REG_MIS;
        end else if (ofs == UIMS_OFS_CLR) begin
            return UIMS_REG_CLR;
        end else begin
            return UIMS_REG_NONE;
        end
    endfunction

    // Field into a bus word; reserved bits come out zero
    function automatic logic [31:0] uims_place(input uims_field_t f);
        return 32'(f) << UIMS_SRC_LSB;
    endfunction

    // Field out of a bus word; reserved bits are dropped
    function automatic uims_field_t uims_pick(input logic [31:0] w);
        return w[UIMS_SRC_MSB:UIMS_SRC_LSB];
    endfunction
endpackage

/* File: core/uims_acc_if.sv */
// Purpose: Register access strobes from the bus front end to the register core
// Assumes: One clock domain
// Notes: Read strobe is in the address phase, write strobe in the data phase
`timescale 1ns/100ps
interface uims_acc_if;
    import uims_pkg::*;
    logic rd_en; // Read taken this cycle (address phase)
    uims_reg_e rd_sel; // Register being read
    logic wr_en; // Write data valid this cycle (data phase)
    uims_reg_e wr_sel; // Register being written
    logic [31:0] wdata; // Write data word

    modport front (output rd_en, rd_sel, wr_en, wr_sel, wdata);
    modport core (input rd_en, rd_sel, wr_en, wr_sel, wdata);
endinterface

/* File: core/uims_ahb_front.sv */
// Purpose: AHB-Lite address phase capture for the interrupt register block
// Assumes: Zero wait states, whole-word single transfers
// Notes: Size and burst signals are not decoded
`timescale 1ns/100ps
module uims_ahb_front import uims_pkg::*; (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic hready_i,
    input wire logic hwrite_i,
    input wire logic [1:0] htrans_i,
    input wire logic [31:0] haddr_i,
    input wire logic [31:0] hwdata_i,
    uims_acc_if.front acc
);
    // Write held over from the address phase
    typedef struct packed {
        logic wr_pend;
        uims_reg_e wr_sel;
    } uims_front_s;

    uims_front_s st_ff; // Registered state
    uims_front_s nxt_st; // Next state
    logic take; // Transfer accepted this cycle
    uims_reg_e sel_now; // Decode of the present address

    // Accept on an active transfer while the bus is ready
    always_comb begin
        take = hsel_i & hready_i & htrans_i[UIMS_HTRANS_ACT];
        sel_now = uims_decode(haddr_i[UIMS_AW-1:0]);
    end

    // Write data arrives one cycle later, so keep the selection
    always_comb begin
        nxt_st = st_ff;
        nxt_st.wr_pend = take & hwrite_i;
        if (take & hwrite_i) begin
            nxt_st.wr_sel = sel_now;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Strobes toward the core
    assign acc.rd_en = take & ~hwrite_i;
    assign acc.rd_sel = sel_now;
    assign acc.wr_en = st_ff.wr_pend;
    assign acc.wr_sel = st_ff.wr_sel;
    assign acc.wdata = hwdata_i;
endmodule // uims_ahb_front

/* File: core/uims_sticky.sv */
// Purpose: Sticky event latches behind the raw interrupt status
// Assumes: Set and clear are one-cycle pulses
// Notes: Set wins over a clear landing in the same cycle
`timescale 1ns/100ps
module uims_sticky import uims_pkg::*; (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire uims_field_t set_i,
    input wire uims_field_t clr_i,
    output uims_field_t q_o,
    output uims_field_t nxt_o
);
    typedef struct packed {
        uims_field_t bits;
    } uims_sticky_s;

    uims_sticky_s st_ff; // Latched events
    uims_sticky_s nxt_st; // Next value
    uims_field_t clr_only; // Clears not overridden by a set

    // An event in the clearing cycle is kept, never lost
    always_comb begin
        nxt_st = st_ff;
        clr_only = clr_i & ~set_i;
        nxt_st.bits = (st_ff.bits & ~clr_i) | set_i;
    end

    // Latch register, all clear from reset
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q_o = st_ff.bits;
    assign nxt_o = nxt_st.bits;

    // A pulse leaves its bit set
    event_sets_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (set_i != UIMS_FIELD_RST) |=> ((q_o & $past(set_i)) == $past(set_i)))
        else $error("event pulse did not set its status bit");

    // A clear with no competing set empties its bit
    clear_works_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (clr_only != UIMS_FIELD_RST) |=> ((q_o & $past(clr_only)) == UIMS_FIELD_RST))
        else $error("clear did not empty the status bit");
endmodule // uims_sticky

/* File: core/uims_irq_core.sv */
// Purpose: Interrupt mask, raw and masked status of an asynchronous serial port
// Assumes: AHB-Lite single whole-word transfers; event inputs are one-cycle pulses
// Notes: Zero wait states; every output is a flip-flop
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/100ps
module uims_irq_core import uims_pkg::*; (
    input wire logic clk_i,
    input wire logic nrst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Event pulses from the serial engine
    input wire logic rx_level_evt_i,
    input wire logic tx_level_evt_i,
    input wire logic rx_timeout_evt_i,
    input wire logic framing_evt_i,
    input wire logic parity_evt_i,
    input wire logic break_evt_i,
    input wire logic overrun_evt_i,
    // Power enable for the receive-timeout detector
    output logic rx_timeout_enable_o,
    // Per-source masked interrupt lines
    output logic rx_level_irq_o,
    output logic tx_level_irq_o,
    output logic rx_timeout_irq_o,
    output logic framing_irq_o,
    output logic parity_irq_o,
    output logic break_irq_o,
    output logic overrun_irq_o,
    // Combined level interrupt
    output logic irq_o
);
    // All state of the register core
    typedef struct packed {
        uims_field_t mask; // Interrupt enable mask
        uims_field_t lines; // Masked interrupt lines
        logic irq; // Combined interrupt
        logic rt_en; // Timeout detector enable
        logic [31:0] rdata; // Read data of the data phase
        logic ready; // Ready to the bus
        logic resp; // Response to the bus
    } uims_core_s;

    uims_core_s st_ff; // Registered state
    uims_core_s nxt_st; // Next state
    uims_field_t evt; // Event pulses packed into field order
    uims_field_t set_vec; // Events allowed into the latches
    uims_field_t clr_vec; // Clear pulses from a bus write
    uims_field_t raw_q; // Latched raw status
    uims_field_t raw_nxt; // Raw status after this edge
    logic evt_none; // No event this cycle

    uims_acc_if acc();

    // Bus front end: address capture and write hold
    uims_ahb_front u_front (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .hsel_i(hsel_i),
        .hready_i(hready_i),
        .hwrite_i(hwrite_i),
        .htrans_i(htrans_i),
        .haddr_i(haddr_i),
        .hwdata_i(hwdata_i),
        .acc(acc)
    );

    // Raw status latches
    uims_sticky u_raw (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .set_i(set_vec),
        .clr_i(clr_vec),
        .q_o(raw_q),
        .nxt_o(raw_nxt)
    );

    // Gather events into their field positions
    // Field order is shared by the mask, raw, masked and clear words
    always_comb begin
        evt = UIMS_FIELD_RST;
        evt[UIMS_I_RX] = rx_level_evt_i;
        evt[UIMS_I_TX] = tx_level_evt_i;
        evt[UIMS_I_RT] = rx_timeout_evt_i;
        evt[UIMS_I_FE] = framing_evt_i;
        evt[UIMS_I_PE] = parity_evt_i;
        evt[UIMS_I_BE] = break_evt_i;
        evt[UIMS_I_OE] = overrun_evt_i;
        evt_none = (evt == UIMS_FIELD_RST);
    end

    // Timeout events only count while its mask bit is one; the detector
    // is also powered from the same bit, so a stray pulse is still blocked
    always_comb begin
        set_vec = evt;
        set_vec[UIMS_I_RT] = evt[UIMS_I_RT] & st_ff.mask[UIMS_I_RT];
    end

    // Clear pulses: ones in a write to the clear register, zeros do nothing
    // Only a data-phase write reaches here, so an address phase cannot clear
    always_comb begin
        clr_vec = UIMS_FIELD_RST;
        if (acc.wr_en && acc.wr_sel == UIMS_REG_CLR) begin
            clr_vec = uims_pick(acc.wdata);
        end
    end

    // Register core next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ready = UIMS_HREADY_RST;
        nxt_st.resp = UIMS_HRESP_OKAY;
        // Mask write; reserved bits are not stored, so they read back zero
        if (acc.wr_en && acc.wr_sel == UIMS_REG_MASK) begin
            nxt_st.mask = uims_pick(acc.wdata);
        end
        // Writes to raw or masked status fall through with no effect
        // Lines follow the post-edge status so they never lag a clear
        nxt_st.lines = raw_nxt & nxt_st.mask;
        nxt_st.irq = |nxt_st.lines;
        nxt_st.rt_en = nxt_st.mask[UIMS_I_RT];
        // Read data uses next values so a write just before is seen
        if (acc.rd_en) begin
            if (acc.rd_sel == UIMS_REG_MASK) begin
                nxt_st.rdata = uims_place(nxt_st.mask);
            end else if (acc.rd_sel == UIMS_REG_RAW) begin
                nxt_st.rdata = uims_place(raw_nxt);
            end else if (acc.rd_sel == UIMS_REG_MIS) begin
                nxt_st.rdata = uims_place(raw_nxt & nxt_st.mask);
            end else begin
                // Clear register and unmapped offsets read zero
                nxt_st.rdata = UIMS_WORD_ZERO;
            end
        end
    end

    // State register; everything disabled after reset
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff.mask <= UIMS_FIELD_RST;
            st_ff.lines <= UIMS_FIELD_RST;
            st_ff.irq <= 1'h0;
            st_ff.rt_en <= 1'h0;
            st_ff.rdata <= UIMS_WORD_ZERO;
            st_ff.ready <= UIMS_HREADY_RST;
            st_ff.resp <= UIMS_HRESP_OKAY;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from flip-flops
    // so the interrupt lines never glitch toward the processor
    assign hrdata_o = st_ff.rdata;
    assign hreadyout_o = st_ff.ready;
    assign hresp_o = st_ff.resp;
    assign rx_timeout_enable_o = st_ff.rt_en;
    assign rx_level_irq_o = st_ff.lines[UIMS_I_RX];
    assign tx_level_irq_o = st_ff.lines[UIMS_I_TX];
    assign rx_timeout_irq_o = st_ff.lines[UIMS_I_RT];
    assign framing_irq_o = st_ff.lines[UIMS_I_FE];
    assign parity_irq_o = st_ff.lines[UIMS_I_PE];
    assign break_irq_o = st_ff.lines[UIMS_I_BE];
    assign overrun_irq_o = st_ff.lines[UIMS_I_OE];
    assign irq_o = st_ff.irq;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Mask takes the written field
    mask_write_a: assert property (
        (acc.wr_en && acc.wr_sel == UIMS_REG_MASK)
        |=> (st_ff.mask == uims_pick($past(acc.wdata))))
        else $error("mask did not take the written value");

    // Mask holds without a mask write
    mask_hold_a: assert property (
        !(acc.wr_en && acc.wr_sel == UIMS_REG_MASK) |=> $stable(st_ff.mask))
        else $error("mask changed without a write");

    // Mask read shows the mask
    mask_read_a: assert property (
        (acc.rd_en && acc.rd_sel == UIMS_REG_MASK) |=> (hrdata_o == uims_place(st_ff.mask)))
        else $error("mask read returned wrong value");

    // Raw read shows the latched sources
    raw_read_a: assert property (
        (acc.rd_en && acc.rd_sel == UIMS_REG_RAW) |=> (hrdata_o == uims_place(raw_q)))
        else $error("raw status read returned wrong value");

    // A write to raw status with no events leaves it unchanged
    raw_readonly_a: assert property (
        (acc.wr_en && acc.wr_sel == UIMS_REG_RAW && evt_none) |=> $stable(raw_q))
        else $error("write changed raw status");

    // Timeout bit stays clear while its mask is zero
    timeout_gate_a: assert property (
        (!st_ff.mask[UIMS_I_RT] && !raw_q[UIMS_I_RT]) |=> !raw_q[UIMS_I_RT])
        else $error("timeout status set while disabled");

    // Masked read is raw AND mask
    masked_read_a: assert property (
        (acc.rd_en && acc.rd_sel == UIMS_REG_MIS)
        |=> (hrdata_o == uims_place(raw_q & st_ff.mask)))
        else $error("masked status read returned wrong value");

    // Reserved bits of every read are zero
    reserved_zero_a: assert property (
        (hrdata_o[31:11] == 21'h0) && (hrdata_o[3:0] == 4'h0))
        else $error("reserved read bits not zero");

    // Lines and combined interrupt track status and mask
    irq_level_a: assert property (
        (st_ff.lines == (raw_q & st_ff.mask)) && (irq_o == |(raw_q & st_ff.mask)))
        else $error("interrupt lines disagree with status and mask");

    // Overrun pulse lands in its own raw bit
    overrun_sets_a: assert property (
        overrun_evt_i |=> raw_q[UIMS_I_OE])
        else $error("overrun event not latched");

    // Receive level pulse lands in its own raw bit
    rx_level_sets_a: assert property (
        rx_level_evt_i |=> raw_q[UIMS_I_RX])
        else $error("receive level event not latched");

    // Transmit level pulse lands in its own raw bit
    tx_level_sets_a: assert property (
        tx_level_evt_i |=> raw_q[UIMS_I_TX])
        else $error("transmit level event not latched");

    // Timeout pulse is latched once its mask bit is one
    timeout_enabled_a: assert property (
        (rx_timeout_evt_i && st_ff.mask[UIMS_I_RT]) |=> raw_q[UIMS_I_RT])
        else $error("enabled timeout event not latched");

    // A gated timeout pulse leaves a clear bit clear
    timeout_blocked_a: assert property (
        (rx_timeout_evt_i && !st_ff.mask[UIMS_I_RT] && !raw_q[UIMS_I_RT])
        |=> !raw_q[UIMS_I_RT])
        else $error("gated timeout event was latched");

    // Detector power follows the timeout mask bit
    timeout_power_a: assert property (
        rx_timeout_enable_o == st_ff.mask[UIMS_I_RT])
        else $error("timeout power differs from its mask bit");

    // Timeout line is its raw bit gated by its mask bit
    timeout_line_a: assert property (
        rx_timeout_irq_o == (raw_q[UIMS_I_RT] && st_ff.mask[UIMS_I_RT]))
        else $error("timeout line differs from masked status");

    // A clear write empties every bit it names, unless an event races it
    clear_write_a: assert property (
        (acc.wr_en && acc.wr_sel == UIMS_REG_CLR)
        |=> ((raw_q & $past(clr_vec) & ~$past(set_vec)) == UIMS_FIELD_RST))
        else $error("clear write left a named bit set");

    // Zero bits of a clear write leave their status alone
    clear_keeps_a: assert property (
        (acc.wr_en && acc.wr_sel == UIMS_REG_CLR)
        |=> ((raw_q | $past(clr_vec)) == ($past(raw_q) | $past(set_vec) | $past(clr_vec))))
        else $error("clear write touched an unnamed bit");

    // With no event and no clear the status stays put
    status_hold_a: assert property (
        (evt_none && clr_vec == UIMS_FIELD_RST) |=> $stable(raw_q))
        else $error("raw status moved with no event or clear");

    // Masked status is read-only as well
    masked_readonly_a: assert property (
        (acc.wr_en && acc.wr_sel == UIMS_REG_MIS && evt_none) |=> $stable(raw_q))
        else $error("write to masked status changed raw status");

    // Read data stands until the next read is taken
    read_hold_a: assert property (
        !acc.rd_en |=> $stable(hrdata_o))
        else $error("read data changed without a read");

    // Clear register and unmapped offsets read zero
    unmapped_read_a: assert property (
        (acc.rd_en && (acc.rd_sel == UIMS_REG_CLR || acc.rd_sel == UIMS_REG_NONE))
        |=> (hrdata_o == UIMS_WORD_ZERO))
        else $error("write-only or unmapped read not zero");

    // The slave never stalls and always answers OKAY
    bus_okay_a: assert property (
        hreadyout_o && (hresp_o == UIMS_HRESP_OKAY))
        else $error("bus answer not ready and OKAY");

    // Combined interrupt is the OR of the seven lines
    irq_any_a: assert property (
        irq_o == (rx_level_irq_o || tx_level_irq_o || rx_timeout_irq_o || framing_irq_o
            || parity_irq_o || break_irq_o || overrun_irq_o))
        else $error("combined interrupt differs from its lines");

    // A disabled break source keeps its line low
    mask_gate_a: assert property (
        !st_ff.mask[UIMS_I_BE] |-> !break_irq_o)
        else $error("break line high while disabled");
endmodule // uims_irq_core

/* File: verif/uims_evt_model.sv */
// Purpose: Behavioural serial engine that raises the interrupt event pulses
// Assumes: Events are one-cycle high pulses launched just after a rising edge
// Notes: The bench decides which sources fire; the receive-timeout pulse is
// Notes: sent even when the detector is unpowered, to probe the gating
`timescale 1ns/100ps
module uims_evt_model import uims_pkg::*; (
    input wire logic clk_i,
    output uims_field_t evt_o
);
    // Quiet until the bench asks for events
    initial begin
        evt_o = UIMS_FIELD_RST;
    end

    // One pulse per requested source; never longer, so a stuck set is visible
    task automatic fire(input uims_field_t f);
        @(posedge clk_i);
        evt_o <= f;
        @(posedge clk_i);
        evt_o <= UIMS_FIELD_RST;
    endtask
endmodule // uims_evt_model

/* File: verif/testbench.sv */
// Purpose: Self-checking bench of the interrupt mask and raw status block
// Assumes: Zero or more wait states; hready is looped back from hreadyout
// Notes: Expected words are built from the package bit positions in the per-source test and written as literals elsewhere
`timescale 1ns/100ps
module testbench import uims_pkg::*; ();
    logic clk_i = 1'b0; // 50 MHz system clock
    logic nrst_i = 1'b0; // Asynchronous reset, low active
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata_o;
    logic hreadyout_o;
    logic hresp_o;
    logic rx_timeout_enable_o;
    logic irq_o;
    uims_field_t evt; // Pulses from the engine model
    uims_field_t lines; // Per-source interrupt lines, bit 0 = receive
    int mismatches = 0;
    int cmp_count = 0;

    // Free-running clock, 20 ns period
    always begin
        #10 clk_i = ~clk_i;
    end

    uims_evt_model engine (.clk_i(clk_i), .evt_o(evt));

    uims_irq_core dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hready_i(hreadyout_o),
        .hwdata_i(hwdata), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .rx_level_evt_i(evt[UIMS_I_RX]),
        .tx_level_evt_i(evt[UIMS_I_TX]), .rx_timeout_evt_i(evt[UIMS_I_RT]),
        .framing_evt_i(evt[UIMS_I_FE]), .parity_evt_i(evt[UIMS_I_PE]),
        .break_evt_i(evt[UIMS_I_BE]), .overrun_evt_i(evt[UIMS_I_OE]),
        .rx_timeout_enable_o(rx_timeout_enable_o), .rx_level_irq_o(lines[0]),
        .tx_level_irq_o(lines[1]), .rx_timeout_irq_o(lines[2]),
        .framing_irq_o(lines[3]), .parity_irq_o(lines[4]),
        .break_irq_o(lines[5]), .overrun_irq_o(lines[6]), .irq_o(irq_o)
    );

    // Count a comparison and report a difference at once
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Single place where the run ends
    task automatic end_of_test();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Next edge with hready high; a stuck slave ends the run
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1 && n < 64) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 64) begin
            mismatches++;
            $display("BAD %0t bus wait ran out", $time);
            end_of_test();
        end
    endtask

    // One single whole-word transfer; read data is taken at the data-phase edge
    task automatic bus(input logic w, input logic [11:0] ofs, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge clk_i);
        hsel <= 1'b1;
        haddr <= {20'h00000, ofs};
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        r = hrdata_o;
    endtask

    task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, ofs, d, r);
    endtask

    // Status words read zero in bits 3:0, yet only 31:4 are judged there
    task automatic rd_chk(input logic [11:0] ofs, input logic [31:0] exp, input string what);
        logic [31:0] r;
        bus(1'b0, ofs, 32'h0000_0000, r);
        check(r & ((ofs == UIMS_OFS_MASK) ? 32'hffff_ffff : 32'hffff_fff0), exp, what);
        check({31'h0, hresp_o}, 32'h0000_0000, "response not OKAY");
    endtask

    // Interrupt lines and their OR, looked at once the bus read has settled
    task automatic chk_irq(input uims_field_t le);
        check({25'h0, lines}, {25'h0, le}, "interrupt lines");
        check({31'h0, irq_o}, {31'h0, |le}, "combined interrupt");
    endtask

    // Reset (also in mid-run) leaves every source disabled and clear
    task automatic t_reset();
        nrst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd_chk(UIMS_OFS_MASK, 32'h0000_0000, "mask after reset");
        rd_chk(UIMS_OFS_RAW, 32'h0000_0000, "raw after reset");
        rd_chk(UIMS_OFS_MIS, 32'h0000_0000, "masked after reset");
        check({31'h0, rx_timeout_enable_o}, 32'h0000_0000, "timeout power");
        chk_irq(7'h00);
        $display("test reset done");
    endtask

    // Each source alone: enable, pulse, see it latched and routed, clear it
    task automatic t_each();
        logic [31:0] m;
        for (int i = 0; i < UIMS_NSRC; i++) begin
            m = 32'h1 << (UIMS_SRC_LSB + i);
            wr(UIMS_OFS_MASK, m);
            rd_chk(UIMS_OFS_MASK, m, "mask readback");
            check({31'h0, rx_timeout_enable_o}, (i == UIMS_I_RT) ? 32'h1 : 32'h0, "tmo");
            engine.fire(7'h01 << i);
            rd_chk(UIMS_OFS_RAW, m, "raw set by event");
            rd_chk(UIMS_OFS_MIS, m, "masked set by event");
            chk_irq(7'h01 << i);
            wr(UIMS_OFS_CLR, m);
            rd_chk(UIMS_OFS_RAW, 32'h0000_0000, "raw after clear");
            chk_irq(7'h00);
        end
        $display("test each source done");
    endtask

    // All sources fire with every mask bit off; timeout stays unpowered
    task automatic t_gated();
        wr(UIMS_OFS_MASK, 32'h0000_0000);
        engine.fire(7'h7f);
        rd_chk(UIMS_OFS_RAW, 32'h0000_07b0, "timeout gated off");
        rd_chk(UIMS_OFS_MIS, 32'h0000_0000, "nothing unmasked");
        chk_irq(7'h00);
        wr(UIMS_OFS_RAW, 32'hffff_ffff);
        wr(12'h100, 32'hffff_ffff);
        wr(UIMS_OFS_MIS, 32'hffff_ffff);
        rd_chk(UIMS_OFS_CLR, 32'h0000_0000, "clear reads zero");
        rd_chk(UIMS_OFS_RAW, 32'h0000_07b0, "raw ignores writes");
        rd_chk(UIMS_OFS_MASK, 32'h0000_0000, "mask untouched");
        wr(UIMS_OFS_CLR, 32'h0000_07f0);
        rd_chk(UIMS_OFS_RAW, 32'h0000_0000, "raw cleared");
        $display("test gated done");
    endtask

    // Partial clears, zero clears and masking off a pending source
    task automatic t_partial();
        wr(UIMS_OFS_MASK, 32'h0000_07f0);
        engine.fire(7'h7f);
        rd_chk(UIMS_OFS_RAW, 32'h0000_07f0, "all raw");
        chk_irq(7'h7f);
        wr(UIMS_OFS_CLR, 32'h0000_0010);
        wr(UIMS_OFS_CLR, 32'h0000_0000);
        rd_chk(UIMS_OFS_RAW, 32'h0000_07e0, "zero clear no effect");
        wr(UIMS_OFS_MASK, 32'h0000_0040);
        rd_chk(UIMS_OFS_MIS, 32'h0000_0040, "only timeout unmasked");
        chk_irq(7'h04);
        wr(UIMS_OFS_MASK, 32'h0000_0000);
        rd_chk(UIMS_OFS_RAW, 32'h0000_07e0, "raw kept when masked");
        chk_irq(7'h00);
        wr(UIMS_OFS_MASK, 32'h0000_0400);
        rd_chk(UIMS_OFS_MIS, 32'h0000_0400, "overrun pending at reset");
        chk_irq(7'h40);
        $display("test partial done");
    endtask

    // Main sequence; the last reset lands with a source pending and unmasked
    initial begin
        t_reset();
        t_each();
        t_gated();
        t_partial();
        t_reset();
        end_of_test();
    end
endmodule // testbench
